// ---- swdtp_consts.svh ----
// Constants for the serial wire debug target packet port
`ifndef SWDTP_CONSTS_SVH
`define SWDTP_CONSTS_SVH

// ==========================================================================
// Acknowledge codes, sent least significant bit first
`define SWDTP_ACK_OK 3'h1
`define SWDTP_ACK_WAIT 3'h2
`define SWDTP_ACK_FAULT 3'h4

// ==========================================================================
// Header bit positions after a full 8-bit shift
`define SWDTP_HDR_START 0
`define SWDTP_HDR_PORT 1
`define SWDTP_HDR_DIR 2
`define SWDTP_HDR_A2 3
`define SWDTP_HDR_A3 4
`define SWDTP_HDR_PAR 5
`define SWDTP_HDR_STOP 6
`define SWDTP_HDR_PARK 7

// ==========================================================================
// Phase lengths counted in serial clock rising edges
`define SWDTP_HDR_LAST 6'h07
`define SWDTP_ACK_BITS 6'h03
`define SWDTP_DATA_BITS 6'h20
`define SWDTP_DATA_END 6'h21
`define SWDTP_RESET_HIGHS 6'h33
`define SWDTP_IDLE_LOWS 6'h03

// ==========================================================================
// Port register addresses A[3:2]
`define SWDTP_DP_IDENT 2'h0
`define SWDTP_DP_RDBUF 2'h3
`define SWDTP_AP_TAR 2'h1
`define SWDTP_AP_DRW 2'h3

// ==========================================================================
// Avalon register byte offsets
`define SWDTP_OFS_CTRL 5'h00
`define SWDTP_OFS_IDENT 5'h04
`define SWDTP_OFS_STATUS 5'h08
`define SWDTP_OFS_TAR 5'h0C
`define SWDTP_OFS_RDBUF 5'h10

`endif

// ---- swdtp_pkg.sv ----
// Types shared by the serial wire debug target packet port
package swdtp_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RDATA = 3'b011,
    ST_WDATA = 3'b100,
    ST_LRESET = 3'b101
  } swdtp_state_type;

  typedef struct packed
  {
    logic port_type_select;
    logic read_not_write;
    logic [1:0] addr;
  } swdtp_req_type;

endpackage : swdtp_pkg

// ---- swdtp_packet_port.sv ----
// Target-side serial wire debug packet engine with Avalon-MM registers
`include "swdtp_consts.svh"

// Summary of operation
// - Second header bit: 1 selects access port, 0 debug port.
// - Third header bit: 1 is a read, 0 is a write.
// - Next two header bits are address bits 2 and 3.
// - Header parity is even parity over port, direction, address.
// - Bad header parity: request ignored, no acknowledge driven.
// - Acknowledge reports the sticky fault, or an access still in flight.
// - WAIT on a read: device leaves data line undriven.
// - WAIT on a write: device ignores the data phase.
// - Bad write data parity makes the next acknowledge FAULT.
// - Device drives acknowledge from the rising edge after park.
// - Second turnaround: nobody drives the line.
// - All fields shift least significant bit first.
// - 51 highs reset the interface; three lows then reach idle.
// - Fixed headers A5, 8B, 9F, BB for the common accesses.
// - Memory access: write transfer address, then data window.
// - Memory read needs two data window reads.
// - Acknowledge codes: OK 001, WAIT 010, FAULT 100.
// - Device samples on rising edges and drives on rising edges.
// - A packet takes 46 serial clocks.
module swdtp_packet_port #(
  parameter int MEM_WORDS = 16,
  parameter int ACCESS_CYCLES = 4,
  parameter logic [31:0] IDENT_RESET = 32'h0000_1001
)(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_SERIAL_DEBUG_CLOCK,
  input wire logic I_DEBUG_DATA_IN,
  output logic O_DEBUG_DATA_OUT,
  output logic O_DEBUG_DATA_OE,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST
);

  localparam int MEM_AW = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;

  generate
    if (MEM_WORDS < 2 || (1 << MEM_AW) != MEM_WORDS || MEM_AW > 30)
    begin : g_bad_mem
      $error("MEM_WORDS must be a power of two, at least 2");
    end
    if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255)
    begin : g_bad_lat
      $error("ACCESS_CYCLES must lie in 1..255");
    end
  endgenerate

  // ========================================================================
  // Pin synchronisers and edge detection
  logic [2:0] clk_sync_reg;
  logic [1:0] din_sync_reg;
  logic sclk_rise;
  logic din;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      clk_sync_reg <= 3'h0;
      din_sync_reg <= 2'h0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], I_SERIAL_DEBUG_CLOCK};
      din_sync_reg <= {din_sync_reg[0], I_DEBUG_DATA_IN};
    end
  end

  // Data is synchronised alongside the clock so both lag equally
  assign sclk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign din = din_sync_reg[1];

  // ========================================================================
  // Line reset detector
  logic [5:0] high_cnt_reg;
  logic line_reset_hit;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
      high_cnt_reg <= 6'h00;
    else if (sclk_rise)
      high_cnt_reg <= !din ? 6'h00 :
        (high_cnt_reg == `SWDTP_RESET_HIGHS) ? high_cnt_reg :
        high_cnt_reg + 6'h01;
  end

  assign line_reset_hit = sclk_rise & din &
    (high_cnt_reg == `SWDTP_RESET_HIGHS - 6'h01);

  // ========================================================================
  // Software registers and access engine state
  logic hold_busy_reg;
  logic [31:0] ident_reg;
  logic [31:0] tar_reg;
  logic [31:0] rdbuf_reg;
  logic busy_reg;
  logic [7:0] timer_reg;
  logic op_wr_reg;
  logic [31:0] op_data_reg;
  logic [MEM_AW-1:0] op_idx_reg;
  logic [31:0] mem [MEM_WORDS];
  logic launch_rd;
  logic launch_wr;
  logic op_done;

  // ========================================================================
  // Packet state machine
  swdtp_pkg::swdtp_state_type state_reg;
  logic [5:0] cnt_reg;
  logic [7:0] hdr_reg;
  logic [7:0] hdr_next;
  swdtp_pkg::swdtp_req_type req_reg;
  swdtp_pkg::swdtp_req_type req_next;
  logic [2:0] ack_reg;
  logic [2:0] ack_next;
  logic [31:0] shift_reg;
  logic [31:0] rdata_next;
  logic discard_reg;
  logic fault_reg;
  logic lreset_seen_reg;
  logic hdr_ok;
  logic wpar_ok;
  logic rpar_reg;

  assign hdr_next = {din, hdr_reg[7:1]};
  assign req_next = '{port_type_select: hdr_next[`SWDTP_HDR_PORT],
    read_not_write: hdr_next[`SWDTP_HDR_DIR],
    addr: {hdr_next[`SWDTP_HDR_A3], hdr_next[`SWDTP_HDR_A2]}};
  assign hdr_ok = hdr_next[`SWDTP_HDR_START]
    & !hdr_next[`SWDTP_HDR_STOP] & hdr_next[`SWDTP_HDR_PARK]
    & (hdr_next[`SWDTP_HDR_PAR] == ^hdr_next[4:1]);
  // Status of the previous packet, fault outranks an access in flight
  assign ack_next = fault_reg ? `SWDTP_ACK_FAULT :
    busy_reg ? `SWDTP_ACK_WAIT : `SWDTP_ACK_OK;
  assign rdata_next =
    (!req_next.port_type_select && req_next.addr == `SWDTP_DP_IDENT) ?
      ident_reg :
    (req_next.addr == `SWDTP_DP_RDBUF) ? rdbuf_reg :
    (req_next.port_type_select && req_next.addr == `SWDTP_AP_TAR) ?
      tar_reg : 32'h0000_0000;
  assign wpar_ok = (din == ^shift_reg);

  // Read of the data window launches a fetch from the transfer address
  assign launch_rd = sclk_rise & (state_reg == swdtp_pkg::ST_HDR) &
    (cnt_reg == `SWDTP_HDR_LAST) & hdr_ok & !fault_reg & !busy_reg &
    req_next.port_type_select & req_next.read_not_write &
    (req_next.addr == `SWDTP_AP_DRW);
  assign launch_wr = sclk_rise & (state_reg == swdtp_pkg::ST_WDATA) &
    (cnt_reg == `SWDTP_DATA_BITS) & !discard_reg & wpar_ok &
    req_reg.port_type_select & (req_reg.addr == `SWDTP_AP_DRW);

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      state_reg <= swdtp_pkg::ST_IDLE;
      cnt_reg <= 6'h00;
      hdr_reg <= 8'h00;
      req_reg <= '0;
      ack_reg <= 3'h0;
      shift_reg <= 32'h0000_0000;
      discard_reg <= 1'b0;
      rpar_reg <= 1'b0;
      fault_reg <= 1'b0;
      lreset_seen_reg <= 1'b0;
      tar_reg <= 32'h0000_0000;
      O_DEBUG_DATA_OUT <= 1'b0;
      O_DEBUG_DATA_OE <= 1'b0;
    end
    else if (line_reset_hit)
    begin
      // Abandons any packet and clears the sticky fault
      state_reg <= swdtp_pkg::ST_LRESET;
      cnt_reg <= 6'h00;
      fault_reg <= 1'b0;
      lreset_seen_reg <= 1'b1;
      O_DEBUG_DATA_OE <= 1'b0;
    end
    else if (sclk_rise)
    begin
      case (state_reg)
        swdtp_pkg::ST_IDLE:
        begin
          hdr_reg <= hdr_next;
          if (din)
          begin
            state_reg <= swdtp_pkg::ST_HDR;
            cnt_reg <= 6'h01;
          end
        end
        swdtp_pkg::ST_HDR:
        begin
          hdr_reg <= hdr_next;
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `SWDTP_HDR_LAST)
          begin
            cnt_reg <= 6'h00;
            req_reg <= req_next;
            ack_reg <= ack_next;
            shift_reg <= rdata_next;
            // Parity taken from the whole word before it is shifted away
            rpar_reg <= ^rdata_next;
            // Bad header: silent return to idle, line never driven
            state_reg <= hdr_ok ? swdtp_pkg::ST_ACK :
              swdtp_pkg::ST_IDLE;
          end
        end
        swdtp_pkg::ST_ACK:
        begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg != `SWDTP_ACK_BITS)
          begin
            O_DEBUG_DATA_OE <= 1'b1;
            O_DEBUG_DATA_OUT <= ack_reg[cnt_reg[1:0]];
          end
          else if (ack_reg == `SWDTP_ACK_OK && req_reg.read_not_write)
          begin
            state_reg <= swdtp_pkg::ST_RDATA;
            cnt_reg <= 6'h01;
            O_DEBUG_DATA_OUT <= shift_reg[0];
            shift_reg <= {1'b0, shift_reg[31:1]};
          end
          else
          begin
            // Released for the turnaround, or for a refused packet
            O_DEBUG_DATA_OE <= 1'b0;
            state_reg <= swdtp_pkg::ST_WDATA;
            cnt_reg <= 6'h00;
            discard_reg <= (ack_reg != `SWDTP_ACK_OK);
            shift_reg <= 32'h0000_0000;
          end
        end
        swdtp_pkg::ST_RDATA:
        begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `SWDTP_DATA_END)
          begin
            O_DEBUG_DATA_OE <= 1'b0;
            state_reg <= swdtp_pkg::ST_IDLE;
          end
          else
          begin
            O_DEBUG_DATA_OUT <= (cnt_reg == `SWDTP_DATA_BITS) ?
              rpar_reg : shift_reg[0];
            shift_reg <= {1'b0, shift_reg[31:1]};
          end
        end
        swdtp_pkg::ST_WDATA:
        begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg != `SWDTP_DATA_BITS)
            shift_reg <= {din, shift_reg[31:1]};
          else
          begin
            state_reg <= swdtp_pkg::ST_IDLE;
            if (!discard_reg)
            begin
              if (!wpar_ok)
                fault_reg <= 1'b1;
              else if (req_reg.port_type_select &&
                req_reg.addr == `SWDTP_AP_TAR)
                tar_reg <= shift_reg;
            end
          end
        end
        swdtp_pkg::ST_LRESET:
        begin
          cnt_reg <= din ? 6'h00 : cnt_reg + 6'h01;
          if (!din && cnt_reg == `SWDTP_IDLE_LOWS - 6'h01)
            state_reg <= swdtp_pkg::ST_IDLE;
        end
        default:
          state_reg <= swdtp_pkg::ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Internal memory access engine
  assign op_done = busy_reg & (timer_reg == 8'h00) & !hold_busy_reg;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      busy_reg <= 1'b0;
      timer_reg <= 8'h00;
      op_wr_reg <= 1'b0;
      op_idx_reg <= '0;
      op_data_reg <= 32'h0000_0000;
    end
    else if (launch_rd || launch_wr)
    begin
      busy_reg <= 1'b1;
      timer_reg <= 8'(ACCESS_CYCLES - 1);
      op_wr_reg <= launch_wr;
      op_idx_reg <= tar_reg[MEM_AW+1:2];
      op_data_reg <= shift_reg;
    end
    else if (busy_reg)
    begin
      if (timer_reg != 8'h00)
        timer_reg <= timer_reg - 8'h01;
      else if (op_done)
        busy_reg <= 1'b0;
    end
  end

  // Memory has no reset; contents are undefined until written
  always_ff @(posedge I_CLOCK)
  begin
    if (op_done && op_wr_reg)
      mem[op_idx_reg] <= op_data_reg;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
      rdbuf_reg <= 32'h0000_0000;
    else if (op_done && !op_wr_reg)
      rdbuf_reg <= mem[op_idx_reg];
  end

  // ========================================================================
  // Avalon-MM slave, one wait state on every access
  logic acc_go;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;

  assign acc_go = (I_AVS_READ | I_AVS_WRITE) & O_AVS_WAITREQUEST;
  assign be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
    {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
  assign status_word = {23'h00_0000, state_reg, busy_reg, fault_reg,
    lreset_seen_reg, ack_reg};
  assign rd_mux =
    (I_AVS_ADDRESS == `SWDTP_OFS_CTRL) ? {31'h0000_0000, hold_busy_reg} :
    (I_AVS_ADDRESS == `SWDTP_OFS_IDENT) ? ident_reg :
    (I_AVS_ADDRESS == `SWDTP_OFS_STATUS) ? status_word :
    (I_AVS_ADDRESS == `SWDTP_OFS_TAR) ? tar_reg :
    (I_AVS_ADDRESS == `SWDTP_OFS_RDBUF) ? rdbuf_reg : 32'h0000_0000;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h0000_0000;
    end
    else
    begin
      O_AVS_WAITREQUEST <= !acc_go;
      if (acc_go && I_AVS_READ)
        O_AVS_READDATA <= rd_mux;
    end
  end

  // Writes land on the edge where the master sees waitrequest low
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      hold_busy_reg <= 1'b0;
      ident_reg <= IDENT_RESET;
    end
    else if (I_AVS_WRITE && !O_AVS_WAITREQUEST)
    begin
      if (I_AVS_ADDRESS == `SWDTP_OFS_CTRL && I_AVS_BYTEENABLE[0])
        hold_busy_reg <= I_AVS_WRITEDATA[0];
      else if (I_AVS_ADDRESS == `SWDTP_OFS_IDENT)
        ident_reg <= (ident_reg & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
    end
  end

endmodule : swdtp_packet_port

// ---- swdtp_packet_port_checker.sv ----
// Concurrent checks on the pins of the debug packet port
// ====================================================
// Checker
module swdtp_packet_port_checker #(
  parameter int MEM_WORDS = 16,
  parameter int ACCESS_CYCLES = 4,
  parameter logic [31:0] IDENT_RESET = 32'h0000_1001
)(
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_SERIAL_DEBUG_CLOCK,
  input wire logic I_DEBUG_DATA_IN,
  input wire logic O_DEBUG_DATA_OUT,
  input wire logic O_DEBUG_DATA_OE,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST
);
  logic sck_reg;
  logic [2:0] since_reg;
  logic [5:0] nb_reg;
  logic [35:0] sh_reg;
  wire rise = I_SERIAL_DEBUG_CLOCK && !sck_reg;
  wire [2:0] ack_cap = (nb_reg == 6'h03) ? sh_reg[35:33] : sh_reg[2:0];
  // Driven bits caught at each serial rise, ack first
  always_ff @(posedge I_CLOCK)
  begin
    sck_reg <= I_SERIAL_DEBUG_CLOCK;
    since_reg <= rise ? 3'h0 : since_reg + {2'h0, since_reg != 3'h7};
    nb_reg <= !O_DEBUG_DATA_OE ? 6'h00 : nb_reg + {5'h00, rise};
    if (O_DEBUG_DATA_OE && rise)
      sh_reg <= {O_DEBUG_DATA_OUT, sh_reg[35:1]};
  end
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET);
  a_wait_once: assert property ((I_AVS_READ || I_AVS_WRITE) &&
    O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST) else $error("no answer");
  a_wait_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_cause: assert property ($fell(O_AVS_WAITREQUEST) |->
    $past(I_AVS_READ) || $past(I_AVS_WRITE)) else $error("stray answer");
  a_unmapped_zero: assert property (!O_AVS_WAITREQUEST && I_AVS_READ &&
    I_AVS_ADDRESS > 5'h10 |-> O_AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  a_drive_edge: assert property ($changed(O_DEBUG_DATA_OE) |->
    since_reg <= 3'h5) else $error("drive change off rising edge");
  a_oe_span: assert property ($fell(O_DEBUG_DATA_OE) |->
    nb_reg == 6'h03 || nb_reg == 6'h24) else $error("bad drive span");
  a_ack_code: assert property ($fell(O_DEBUG_DATA_OE) |->
    ack_cap inside {3'h1, 3'h2, 3'h4}) else $error("bad ack code");
  a_read_ok: assert property ($fell(O_DEBUG_DATA_OE) &&
    nb_reg == 6'h24 |-> ack_cap == 3'h1) else $error("data after non-OK");
  a_read_par: assert property ($fell(O_DEBUG_DATA_OE) &&
    nb_reg == 6'h24 |-> ^sh_reg[35:3] == 1'b0) else $error("read parity");
  c_read: cover property ($fell(O_DEBUG_DATA_OE) && nb_reg == 6'h24);
  c_wait: cover property ($fell(O_DEBUG_DATA_OE) && ack_cap == 3'h2);
  c_fault: cover property ($fell(O_DEBUG_DATA_OE) && ack_cap == 3'h4);
endmodule : swdtp_packet_port_checker

// ---- swdtp_host_model.sv ----
// Host programmer model driving serial clock and data line
// ====================================================
// Host model
module swdtp_host_model (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_sclk,
  output logic o_data,
  output logic o_drive
);
  initial
  begin
    o_sclk = 1'b0;
    o_data = 1'b0;
    o_drive = 1'b1;
  end
  // Read just before the next rise: device bit stands a whole cycle
  task automatic cyc(input logic d, input logic b, output logic s);
    o_drive <= d;
    if (d)
      o_data <= b;
    repeat (4) @(posedge i_clock);
    s = i_line;
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_sclk <= 1'b0;
  endtask : cyc
  task automatic pkt(input logic [7:0] h, input logic [31:0] wd,
    input logic bad, output logic [2:0] ack, output logic [31:0] rd,
    output logic rp);
    logic s;
    for (int k = 1; k <= 46; k++)
    begin
      if (k <= 8)
        cyc(1'b1, h[k-1], s);
      else if (k <= 12 || h[2])
        cyc(1'b0, 1'b0, s);
      else if (k <= 44)
        cyc(1'b1, wd[k-13], s);
      else
        cyc(1'b1, (k == 45) && (^wd ^ bad), s);
      if (k >= 10 && k <= 12)
        ack[k-10] = s;
      if (k >= 13 && k <= 44)
        rd[k-13] = s;
      if (k == 45)
        rp = s;
    end
    repeat (3) cyc(1'b1, 1'b0, s);
  endtask : pkt
  task automatic lreset();
    logic s;
    repeat (52) cyc(1'b1, 1'b1, s);
    repeat (3) cyc(1'b1, 1'b0, s);
  endtask : lreset
endmodule : swdtp_host_model

// ---- swdtp_packet_port_bench.sv ----
// Self-checking bench for the debug packet port
// ====================================================
// Bench
module swdtp_packet_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID0 = 32'h0000_1001; // Arbitrary identity
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdata, q, ad, dv, rv;
  logic [31:0] seed = 32'hB93B84FD;
  logic wq, dout, doe, sck, hd, hdrv, rp, oe_d;
  logic [2:0] ak;
  int error_cnt = 0;
  int n_tests = 0;
  int oe_n = 0;
  int n0;
  int wait_n = 0;
  // Released line shows the inverse of the last host bit
  wire line = doe ? dout : (hdrv ? hd : !hd);
  swdtp_packet_port #(.IDENT_RESET(ID0)) u_swdtp_packet_port (
    .I_CLOCK(clk), .I_RESET(rst), .I_SERIAL_DEBUG_CLOCK(sck),
    .I_DEBUG_DATA_IN(line), .O_DEBUG_DATA_OUT(dout),
    .O_DEBUG_DATA_OE(doe), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq));
  swdtp_host_model u_swdtp_host_model (.i_clock(clk), .i_line(line),
    .o_sclk(sck), .o_data(hd), .o_drive(hdrv));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    oe_d <= doe;
    if (doe === 1'b1 && oe_d === 1'b0)
      oe_n++;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic avs(input logic we, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !we;
    wr <= we;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wq !== 1'b0 && n < 64);
    r = rdata;
    if (n == 64)
      error_cnt++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avs
  task automatic pk(input logic [7:0] h, input logic [31:0] d,
    input logic bad, input logic [2:0] ea);
    u_swdtp_host_model.pkt(h, d, bad, ak, rv, rp);
    chk({29'h0, ak}, {29'h0, ea});
    wait_n = (ak == 3'h2) ? wait_n + 1 : 0;
  endtask : pk
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    avs(1'b0, 5'h04, 32'h0, q);
    chk(q, ID0);
    avs(1'b0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
    seed = nxt(seed);
    dv = seed;
    avs(1'b1, 5'h04, dv, q);
    u_swdtp_host_model.lreset();
    avs(1'b0, 5'h08, 32'h0, q);
    chk({31'h0, q[3]}, 32'h1);
    pk(8'hA5, 32'h0, 1'b0, 3'h1);
    chk(rv, dv);
    chk({31'h0, rp}, {31'h0, ^dv});
    n0 = oe_n;
    u_swdtp_host_model.pkt(8'h9B, 32'h0, 1'b0, ak, rv, rp);
    chk(32'(oe_n), 32'(n0));
    pk(8'hA5, 32'h0, 1'b0, 3'h1);
    for (int i = 0; i < 4; i++)
    begin
      seed = nxt(seed);
      ad = seed;
      seed = nxt(seed);
      dv = seed;
      pk(8'h8B, ad, 1'b0, 3'h1);
      avs(1'b0, 5'h0C, 32'h0, q);
      chk(q, ad);
      pk(8'hAF, 32'h0, 1'b0, 3'h1);
      chk(rv, ad);
      pk(8'hBB, dv, 1'b0, 3'h1);
      pk(8'h9F, 32'h0, 1'b0, 3'h1);
      pk(8'h9F, 32'h0, 1'b0, 3'h1);
      chk(rv, dv);
    end
    pk(8'hBD, 32'h0, 1'b0, 3'h1);
    chk(rv, dv);
    avs(1'b1, 5'h00, 32'h1, q);
    // Hold keeps the read launched by the first packet busy, so the next two packets see WAIT
    pk(8'h9F, 32'h0, 1'b0, 3'h1);
    pk(8'hBB, ~dv, 1'b0, 3'h2);
    pk(8'h9F, 32'h0, 1'b0, 3'h2);
    chk(32'(wait_n), 32'h2);
    avs(1'b1, 5'h00, 32'h0, q);
    pk(8'h9F, 32'h0, 1'b0, 3'h1);
    pk(8'h9F, 32'h0, 1'b0, 3'h1);
    chk(rv, dv);
    pk(8'hBB, dv, 1'b1, 3'h1);
    pk(8'hA5, 32'h0, 1'b0, 3'h4);
    pk(8'hA5, 32'h0, 1'b0, 3'h4);
    u_swdtp_host_model.lreset();
    pk(8'hA5, 32'h0, 1'b0, 3'h1);
    close_out();
  end
endmodule : swdtp_packet_port_bench
bind swdtp_packet_port swdtp_packet_port_checker #(.MEM_WORDS(MEM_WORDS),
  .ACCESS_CYCLES(ACCESS_CYCLES), .IDENT_RESET(IDENT_RESET)) u_chk (
  .I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
  .I_SERIAL_DEBUG_CLOCK(I_SERIAL_DEBUG_CLOCK),
  .I_DEBUG_DATA_IN(I_DEBUG_DATA_IN), .O_DEBUG_DATA_OUT(O_DEBUG_DATA_OUT),
  .O_DEBUG_DATA_OE(O_DEBUG_DATA_OE), .I_AVS_ADDRESS(I_AVS_ADDRESS),
  .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));
